// File: rtl/obl_loader.sv
// Purpose: Boot-time option byte loader with the watchdog it configures
// Assumes: boot_swap_i, standby_i, lsoc_clk_i are pins; APB master on clk_i
// Notes:   cpu_run_o stays low until all four bytes are latched
`timescale 1ns/1ns
`default_nettype none
module obl_loader
  import obl_pkg::*;
#(
  parameter logic [63:0] IMAGE = OBL_IMAGE_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic boot_swap_i,
  input wire logic standby_i,
  input wire logic lsoc_clk_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Configuration outputs
  output obl_wdt_cfg_t wdt_cfg_o,
  output obl_sys_cfg_t sys_cfg_o,
  output logic cpu_run_o,
  // Watchdog and interrupt
  output logic wdt_reset_req_o,
  output logic irq_o
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] meta_ff;     // First stage, read only by second stage
  logic [2:0] sync_ff;     // Second stage
  logic lsoc_prev_ff;      // Previous low speed clock level
  logic swap_s;            // Synchronised boot swap
  logic stby_s;            // Synchronised standby
  logic lsoc_rise;         // One low speed clock cycle elapsed

  // Two flip-flops for each pin, kept out of reset on purpose:
  // the swap level must already be settled when the loader leaves reset
  always_ff @(posedge clk_i) begin
    meta_ff <= {lsoc_clk_i, standby_i, boot_swap_i};
    sync_ff <= meta_ff;
    lsoc_prev_ff <= sync_ff[2];  // Tracks the pin, so no false edge after reset
  end

  assign swap_s = sync_ff[0];
  assign stby_s = sync_ff[1];
  assign lsoc_rise = sync_ff[2] & ~lsoc_prev_ff;

  // ==========================================================================
  // Loader state machine
  // ==========================================================================
  obl_state_t state_ff, nxt_state;   // Loader state
  logic [1:0] idx_ff, nxt_idx;       // Byte being fetched
  logic bank_ff, nxt_bank;           // Active copy region
  logic [3:0][7:0] opt_ff, nxt_opt;  // Latched option bytes
  logic [2:0] mem_addr;              // Store address
  logic [7:0] mem_rdata;             // Store read data
  logic loaded_evt;                  // Pulse when loading completes

  // Option byte store
  obl_optmem #(
    .IMAGE(IMAGE)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raddr_i(mem_addr),
    .rdata_o(mem_rdata)
  );

  // Physical region chosen by the swap state
  assign mem_addr = {bank_ff, idx_ff};

  // Next state of loader
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_bank = bank_ff;
    nxt_opt = opt_ff;
    loaded_evt = 1'b0;
    unique case (state_ff)
      OBL_ST_IDLE: begin
        // Boot swap selects which copy appears at the primary addresses
        nxt_bank = swap_s ? OBL_BANK_DUPLICATE : OBL_BANK_PRIMARY;
        nxt_idx = 2'h0;
        nxt_state = OBL_ST_FETCH;
      end
      OBL_ST_FETCH: begin
        // Address presented, data next cycle
        nxt_state = OBL_ST_CAPTURE;
      end
      OBL_ST_CAPTURE: begin
        // Latch byte and step on
        nxt_opt[idx_ff] = mem_rdata;
        if (idx_ff == 2'(OBL_NUM_BYTES - 1)) begin
          nxt_state = OBL_ST_DONE;
          loaded_evt = 1'b1;
        end else begin
          nxt_idx = idx_ff + 2'h1;
          nxt_state = OBL_ST_FETCH;
        end
      end
      OBL_ST_DONE: begin
        // Hold until the next reset
        nxt_state = OBL_ST_DONE;
      end
    endcase
  end

  // Loader registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= OBL_ST_IDLE;
      idx_ff <= 2'h0;
      bank_ff <= OBL_BANK_PRIMARY;
      opt_ff <= '0;
      cpu_run_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      bank_ff <= nxt_bank;
      opt_ff <= nxt_opt;
      cpu_run_o <= (nxt_state == OBL_ST_DONE);
    end
  end

  // ==========================================================================
  // Decoded configuration
  // ==========================================================================
  obl_wdt_cfg_t wdt_cfg;   // Watchdog byte fields
  obl_sys_cfg_t sys_cfg;   // Other bytes decoded

  // Field split of the latched bytes
  always_comb begin
    wdt_cfg = obl_wdt_cfg_t'(opt_ff[0]);
    sys_cfg.vdet_byte = opt_ff[1];
    sys_cfg.vdet_reset_mode = (opt_ff[1][OBL_VDET_MODE_LSB +: 2] == OBL_VDET_MODE_RESET);
    sys_cfg.high_speed_flash_mode = (opt_ff[2][OBL_OSC_FLASH_MODE_LSB +: 2] == OBL_OSC_FLASH_MODE_HIGH);
    sys_cfg.osc_freq_sel = opt_ff[2][OBL_OSC_FRQ_LSB +: 4];
    sys_cfg.osc_32mhz = (opt_ff[2][OBL_OSC_FRQ_LSB +: 4] == OBL_OSC_FRQ_32MHZ);
    sys_cfg.ocd_enable = opt_ff[3][OBL_DBG_ENABLE_BIT];
  end

  // ==========================================================================
  // Watchdog counter
  // ==========================================================================
  logic [16:0] cnt_ff, nxt_cnt;  // Count of low speed cycles
  logic [16:0] period;           // Overflow period
  logic [16:0] intv_pt;          // Interval interrupt point
  logic [16:0] win_open;         // First count of open window
  logic intv_done_ff, nxt_intv_done;  // Interval raised this period
  logic wdt_run;                 // Counter running
  logic kick;                    // Software restart
  logic evt_intv, evt_ovf, evt_win;   // Watchdog events

  // Period and thresholds from the option fields
  always_comb begin
    period = 17'h0_0001 << OBL_OVF_EXP[wdt_cfg.overflow_time_sel];
    intv_pt = period - (period >> 2);
    unique case ({wdt_cfg.window_period_sel_hi, wdt_cfg.window_period_sel_lo})
      OBL_WIN_50: win_open = period >> 1;
      OBL_WIN_75: win_open = period >> 2;
      OBL_WIN_100: win_open = OBL_WDT_CNT_RESET;
      OBL_WIN_PROHIBITED: win_open = OBL_WDT_CNT_RESET;  // Treated as fully open
    endcase
  end

  // Counting, overflow, window and interval detection
  always_comb begin
    // Runs only after loading and only if the run bit is set
    wdt_run = (state_ff == OBL_ST_DONE) & wdt_cfg.run_after_reset;
    nxt_cnt = cnt_ff;
    nxt_intv_done = intv_done_ff;
    evt_intv = 1'b0;
    evt_ovf = 1'b0;
    evt_win = 1'b0;
    if (wdt_run) begin
      if (kick) begin
        // Restart before the window opens is an error
        evt_win = (cnt_ff < win_open);
        nxt_cnt = OBL_WDT_CNT_RESET;
        nxt_intv_done = 1'b0;
      end else if (lsoc_rise && !(stby_s && !wdt_cfg.standby_count_enable)) begin
        // One low speed cycle counted
        if (cnt_ff == period - 17'h0_0001) begin
          evt_ovf = 1'b1;
          nxt_cnt = OBL_WDT_CNT_RESET;
          nxt_intv_done = 1'b0;
        end else begin
          nxt_cnt = cnt_ff + 17'h0_0001;
        end
        // Interval point reached once per period
        if (wdt_cfg.interval_irq_use && !intv_done_ff && nxt_cnt == intv_pt) begin
          evt_intv = 1'b1;
          nxt_intv_done = 1'b1;
        end
      end
    end
  end

  // Watchdog registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= OBL_WDT_CNT_RESET;
      intv_done_ff <= 1'b0;
      wdt_reset_req_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      intv_done_ff <= nxt_intv_done;
      wdt_reset_req_o <= evt_ovf | evt_win;
    end
  end

  // ==========================================================================
  // APB register file
  // ==========================================================================
  logic [OBL_EVT_W-1:0] status_ff, nxt_status;  // Sticky events
  logic [OBL_EVT_W-1:0] mask_ff, nxt_mask;      // Interrupt enables
  logic [31:0] nxt_prdata;     // Read data for the access phase
  logic nxt_pready;            // Ready in the access phase
  logic nxt_pslverr;           // Error answer
  logic [9:0] widx;            // Word index of the access
  logic setup;                 // Setup cycle
  logic commit;                // Access completes this edge
  logic [OBL_EVT_W-1:0] set_evt;  // Events this cycle

  assign widx = paddr_i[OBL_ADDR_MSB:2];
  assign setup = psel_i & ~penable_i;
  assign commit = psel_i & penable_i & pready_o;
  assign kick = commit & pwrite_i & (widx == OBL_IDX_KICK);

  // Decode, read mux and register updates
  always_comb begin
    nxt_pready = setup;
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (setup) begin
      unique case (widx)
        OBL_IDX_STATUS: nxt_prdata = 32'(status_ff);
        OBL_IDX_MASK: nxt_prdata = 32'(mask_ff);
        OBL_IDX_KICK: nxt_pslverr = ~pwrite_i;
        OBL_IDX_WDT_COUNT: nxt_prdata = {14'h0000, wdt_run, cnt_ff};
        // Option bytes answer reads and refuse writes
        OBL_IDX_WDT_OPT: begin
          nxt_prdata = {24'h00_0000, opt_ff[0]};
          nxt_pslverr = pwrite_i;
        end
        OBL_IDX_VDET_OPT: begin
          nxt_prdata = {24'h00_0000, opt_ff[1]};
          nxt_pslverr = pwrite_i;
        end
        OBL_IDX_OSC_OPT: begin
          nxt_prdata = {24'h00_0000, opt_ff[2]};
          nxt_pslverr = pwrite_i;
        end
        OBL_IDX_DBG_OPT: begin
          nxt_prdata = {24'h00_0000, opt_ff[3]};
          nxt_pslverr = pwrite_i;
        end
        default: nxt_pslverr = 1'b1;  // Unmapped address
      endcase
      if (pwrite_i) begin
        nxt_prdata = 32'h0000_0000;
      end
    end
    // Event collection, set wins over write-one clear
    set_evt = '0;
    set_evt[OBL_EVT_INTERVAL] = evt_intv;
    set_evt[OBL_EVT_OVERFLOW] = evt_ovf;
    set_evt[OBL_EVT_WINDOW] = evt_win;
    set_evt[OBL_EVT_LOADED] = loaded_evt;
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    if (commit && pwrite_i && widx == OBL_IDX_STATUS) begin
      nxt_status = status_ff & ~pwdata_i[OBL_EVT_W-1:0];
    end
    if (commit && pwrite_i && widx == OBL_IDX_MASK) begin
      nxt_mask = pwdata_i[OBL_EVT_W-1:0];
    end
    nxt_status = nxt_status | set_evt;
  end

  // Bus and interrupt registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= '0;
      mask_ff <= OBL_MASK_RESET;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
      wdt_cfg_o <= '0;
      sys_cfg_o <= '0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      prdata_o <= nxt_prdata;
      pready_o <= nxt_pready;
      pslverr_o <= nxt_pslverr;
      irq_o <= |(nxt_status & nxt_mask);
      wdt_cfg_o <= wdt_cfg;
      sys_cfg_o <= sys_cfg;
    end
  end

endmodule
`default_nettype wire

// File: rtl/obl_optmem.sv
// Purpose: Read-only store of the option bytes, primary and duplicate copy
// Assumes: Contents fixed by the stored image parameter
// Notes:   Read data come out of a register one cycle after the address
`timescale 1ns/1ns
`default_nettype none
module obl_optmem
  import obl_pkg::*;
#(
  parameter logic [63:0] IMAGE = OBL_IMAGE_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Read port
  input wire logic [2:0] raddr_i,
  output logic [7:0] rdata_o
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] rdata_ff;   // Registered read data
  logic [7:0] nxt_rdata;  // Selected byte

  // Byte select from the fixed image, no write port exists
  always_comb begin
    nxt_rdata = IMAGE[{raddr_i, 3'h0} +: 8];
  end

  // Read register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

endmodule
`default_nettype wire

// File: rtl/obl_pkg.sv
// Purpose: Shared constants and types of the option byte configuration loader
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes:   Register indices are word indices; byte address is four times the index
package obl_pkg;

  // ==========================================================================
  // Option byte store layout
  // ==========================================================================
  localparam int unsigned OBL_NUM_BYTES = 4;          // Bytes in one copy region
  localparam int unsigned OBL_MEM_DEPTH = 8;          // Primary plus duplicate copy
  localparam logic [2:0] OBL_AW = 3'h3;               // Memory address width
  localparam logic OBL_BANK_PRIMARY = 1'b0;           // Region of 000C0H..000C3H
  localparam logic OBL_BANK_DUPLICATE = 1'b1;         // Region of 010C0H..010C3H
  localparam logic [19:0] OBL_PRIMARY_BASE = 20'h0_00C0;   // Primary copy base
  localparam logic [19:0] OBL_DUPLICATE_BASE = 20'h0_10C0; // Duplicate copy base
  // Stored image, byte n of the store at bits 8n+7..8n
  localparam logic [63:0] OBL_IMAGE_DEFAULT = 64'h84E8_7F6E_84E8_7F6E;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  // ==========================================================================
  localparam logic [9:0] OBL_IDX_STATUS = 10'h000;    // Sticky event flags, W1C
  localparam logic [9:0] OBL_IDX_MASK = 10'h001;      // Interrupt mask
  localparam logic [9:0] OBL_IDX_KICK = 10'h002;      // Watchdog restart, write only
  localparam logic [9:0] OBL_IDX_WDT_COUNT = 10'h003; // Watchdog count and state
  localparam logic [9:0] OBL_IDX_WDT_OPT = 10'h0C0;   // watchdog_option_byte
  localparam logic [9:0] OBL_IDX_VDET_OPT = 10'h0C1;  // voltage_detect_option_byte
  localparam logic [9:0] OBL_IDX_OSC_OPT = 10'h0C2;   // oscillator_flash_option_byte
  localparam logic [9:0] OBL_IDX_DBG_OPT = 10'h0C3;   // debug_option_byte
  localparam logic [11:0] OBL_ADDR_MSB = 12'h00B;     // Top bit of paddr

  // ==========================================================================
  // Status and mask bit positions
  // ==========================================================================
  localparam int unsigned OBL_EVT_W = 4;              // Number of event bits
  localparam int unsigned OBL_EVT_INTERVAL = 0;       // Interval point reached
  localparam int unsigned OBL_EVT_OVERFLOW = 1;       // Watchdog overflow
  localparam int unsigned OBL_EVT_WINDOW = 2;         // Restart outside open window
  localparam int unsigned OBL_EVT_LOADED = 3;         // Option bytes loaded
  localparam logic [3:0] OBL_MASK_RESET = 4'h0;       // All events masked

  // ==========================================================================
  // Option byte field positions
  // ==========================================================================
  localparam int unsigned OBL_VDET_MODE_LSB = 0;      // Detector mode, 2 bits
  localparam logic [1:0] OBL_VDET_MODE_RESET = 2'h3;  // Reset mode code
  localparam int unsigned OBL_OSC_FLASH_MODE_LSB = 6; // Flash mode, 2 bits
  localparam logic [1:0] OBL_OSC_FLASH_MODE_HIGH = 2'h3; // High speed flash mode
  localparam int unsigned OBL_OSC_FRQ_LSB = 0;        // Oscillator select, 4 bits
  localparam logic [3:0] OBL_OSC_FRQ_32MHZ = 4'h8;    // 32 MHz select code
  localparam int unsigned OBL_DBG_ENABLE_BIT = 7;     // On-chip debug enable

  // ==========================================================================
  // Watchdog timing
  // ==========================================================================
  // Overflow exponent per select code, index 7 first (2^exp low speed cycles)
  localparam logic [7:0][4:0] OBL_OVF_EXP = '{5'h10, 5'h0E, 5'h0D, 5'h0B,
                                              5'h09, 5'h08, 5'h07, 5'h06};
  localparam logic [1:0] OBL_WIN_PROHIBITED = 2'h0;   // Window code not allowed
  localparam logic [1:0] OBL_WIN_50 = 2'h1;           // 50 percent open
  localparam logic [1:0] OBL_WIN_75 = 2'h2;           // 75 percent open
  localparam logic [1:0] OBL_WIN_100 = 2'h3;          // Always open
  localparam logic [16:0] OBL_WDT_CNT_RESET = 17'h0_0000; // Counter reset value

  // ==========================================================================
  // Types
  // ==========================================================================
  // Watchdog option byte, bit 7 down to bit 0
  typedef struct packed {
    logic interval_irq_use;
    logic window_period_sel_hi;
    logic window_period_sel_lo;
    logic run_after_reset;
    logic [2:0] overflow_time_sel;
    logic standby_count_enable;
  } obl_wdt_cfg_t;

  // Decoded settings of the other three bytes
  typedef struct packed {
    logic vdet_reset_mode;
    logic [7:0] vdet_byte;
    logic high_speed_flash_mode;
    logic [3:0] osc_freq_sel;
    logic osc_32mhz;
    logic ocd_enable;
  } obl_sys_cfg_t;

  // Loader states
  typedef enum logic [1:0] {
    OBL_ST_IDLE = 2'b00,
    OBL_ST_FETCH = 2'b01,
    OBL_ST_CAPTURE = 2'b10,
    OBL_ST_DONE = 2'b11
  } obl_state_t;

endpackage

// File: tb/obl_loader_asserts.sv
// Purpose: Port checks of the option byte loader
// Assumes: One clock domain, synchronous reset
// Notes:   Bound into obl_loader
`timescale 1ns/1ns
`default_nettype none
module obl_loader_asserts
  import obl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Results
  input wire obl_wdt_cfg_t wdt_cfg_o,
  input wire obl_sys_cfg_t sys_cfg_o,
  input wire logic cpu_run_o,
  input wire logic wdt_reset_req_o
);
  // ====================
  // Clocking and helpers
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Access phase of an option register
  logic opt_acc;
  assign opt_acc = psel_i && penable_i && pready_o && (paddr_i[11:4] == 8'h30);
  // Load steps after release
  sequence s_released;
    $past(rst_i) && !rst_i;
  endsequence
  sequence s_loading;
    !cpu_run_o [*8] ##1 !cpu_run_o ##1 cpu_run_o;
  endsequence
  sequence s_loaded;
    cpu_run_o ##1 cpu_run_o;
  endsequence
  // ====================
  // Assertions
  AST_LOAD_TIME: assert property (s_released |-> s_loading)
    else $error("cpu run not on ninth edge");
  AST_RUN_HOLD: assert property (cpu_run_o |=> cpu_run_o)
    else $error("cpu run dropped");
  AST_CFG_STABLE: assert property (s_loaded |=> $stable(wdt_cfg_o) && $stable(sys_cfg_o))
    else $error("config changed after load");
  AST_OPT_WR_ERR: assert property (opt_acc && pwrite_i |-> pslverr_o)
    else $error("option write accepted");
  AST_OPT_RD_OK: assert property (opt_acc && !pwrite_i && cpu_run_o |-> !pslverr_o)
    else $error("option read refused");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_VDET_DECODE: assert property (s_loaded |-> sys_cfg_o.vdet_reset_mode == (sys_cfg_o.vdet_byte[1:0] == 2'b11))
    else $error("detector mode decode wrong");
  AST_OSC_DECODE: assert property (s_loaded |-> sys_cfg_o.osc_32mhz == (sys_cfg_o.osc_freq_sel == 4'h8))
    else $error("oscillator decode wrong");
  AST_REQ_PULSE: assert property (wdt_reset_req_o |=> !wdt_reset_req_o)
    else $error("reset request longer than a cycle");
  AST_STOPPED: assert property (cpu_run_o && !wdt_cfg_o.run_after_reset && wdt_cfg_o.window_period_sel_hi
    && wdt_cfg_o.window_period_sel_lo |-> !wdt_reset_req_o)
    else $error("stopped watchdog asked reset");
endmodule
bind obl_loader obl_loader_asserts u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o,
  .pslverr_o, .wdt_cfg_o, .sys_cfg_o, .cpu_run_o, .wdt_reset_req_o);
`default_nettype wire

// File: tb/obl_loader_test.sv
// Purpose: Self-checking bench of the option byte loader
// Assumes: 100 MHz clock, bench acts as APB master
// Notes:   Copies differ on purpose to show which one is fetched
`timescale 1ns/1ns
`default_nettype none
module obl_loader_test
  import obl_pkg::*;
();
  // ====================
  // Stimulus, outputs, model
  localparam logic [63:0] IMG = 64'h0460_7DB0_84E8_7F6E; // Duplicate runs the watchdog
  localparam int PER = 64; // Select 000 period
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic boot_swap_i = 1'b0;
  logic standby_i = 1'b0;
  logic lsoc_clk_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  obl_wdt_cfg_t wdt_cfg_o;
  obl_sys_cfg_t sys_cfg_o;
  logic cpu_run_o;
  logic wdt_reset_req_o;
  logic irq_o;
  int err_total = 0;
  int samples_checked = 0;
  int req_seen = 0; // Reset request pulses seen
  int m_cnt, m_st, m_req, m_mask; // Model watchdog state
  logic [31:0] rd;
  logic er;
  // Clock
  always #5 clk_i = ~clk_i;
  // Count request pulses
  always @(posedge clk_i) if (wdt_reset_req_o === 1'b1) req_seen <= req_seen + 1;
  // Design under test
  obl_loader #(.IMAGE(IMG)) dut (.clk_i, .rst_i, .boot_swap_i, .standby_i, .lsoc_clk_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .wdt_cfg_o, .sys_cfg_o, .cpu_run_o,
    .wdt_reset_req_o, .irq_o);
  // ====================
  // Tasks
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 8) begin
      err_total++;
      close_out();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Low speed edges with model counting
  task automatic lsoc_edges(input int n, input logic run);
    repeat (n) begin
      lsoc_clk_i <= 1'b1;
      repeat (3 + $urandom % 3) @(posedge clk_i);
      lsoc_clk_i <= 1'b0;
      repeat (3 + $urandom % 3) @(posedge clk_i);
      if (run && !standby_i) begin
        if (m_cnt == PER - 1) begin
          m_cnt = 0;
          m_st |= 2;
          m_req++;
        end else begin
          m_cnt++;
          if (m_cnt == PER * 3 / 4) m_st |= 1;
        end
      end
    end
  endtask
  // Restart, error if before window opens
  task automatic kick(input int win_start);
    apb(1'b1, ad(OBL_IDX_KICK), $urandom);
    if (m_cnt < win_start) begin
      m_st |= 4;
      m_req++;
    end
    m_cnt = 0;
  endtask
  task automatic clr(input int v);
    apb(1'b1, ad(OBL_IDX_STATUS), 32'(v));
    m_st &= ~v;
  endtask
  // Compare watchdog state with model
  task automatic chk_wdt();
    apb(1'b0, ad(OBL_IDX_WDT_COUNT), 32'h0000_0000);
    chk("count", {15'h0, rd[16:0]}, 32'(m_cnt));
    apb(1'b0, ad(OBL_IDX_STATUS), 32'h0000_0000);
    chk("status", {28'h0, rd[3:0]}, 32'(m_st));
    chk("reset_req", 32'(req_seen), 32'(m_req));
    chk("irq", {31'h0, irq_o}, 32'((m_st & m_mask) != 0));
  endtask
  // Reset, load and check one copy
  task automatic boot(input logic swap);
    logic [7:0] b [4];
    logic [15:0] e;
    int k;
    for (k = 0; k < 4; k++) b[k] = IMG[(32 * int'(swap) + 8 * k) +: 8];
    e = {b[1][1:0] == 2'b11, b[1], b[2][7:6] == 2'b11, b[2][3:0], b[2][3:0] == 4'h8, b[3][7]};
    boot_swap_i <= swap;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("run_in_reset", {31'h0, cpu_run_o}, 32'h0000_0000);
    chk("cfg_in_reset", {24'h0, wdt_cfg_o}, 32'h0000_0000);
    rst_i <= 1'b0;
    for (k = 0; k < 30 && cpu_run_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 30) begin
      err_total++;
      close_out();
    end
    repeat (2) @(posedge clk_i);
    chk("wdt_cfg", {24'h0, wdt_cfg_o}, {24'h0, b[0]});
    chk("sys_cfg", {16'h0, sys_cfg_o}, {16'h0, e});
    m_cnt = 0;
    m_st = 8;
    m_mask = 0;
    m_req = req_seen;
    apb(1'b0, ad(OBL_IDX_MASK), 32'h0000_0000);
    chk("mask_reset", rd, {28'h0, OBL_MASK_RESET});
    for (k = 0; k < 4; k++) begin
      apb(1'b0, ad(OBL_IDX_WDT_OPT + 10'(k)), 32'h0000_0000);
      chk("opt_read", rd, {24'h0, b[k]});
      apb(1'b1, ad(OBL_IDX_WDT_OPT + 10'(k)), $urandom);
      chk("opt_write_err", {31'h0, er}, 32'h0000_0001);
      apb(1'b0, ad(OBL_IDX_WDT_OPT + 10'(k)), 32'h0000_0000);
      chk("opt_kept", rd, {24'h0, b[k]});
    end
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    chk("cfg_kept", {24'h0, wdt_cfg_o}, {24'h0, b[0]});
  endtask
  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h8b57));
    boot(1'b0);
    $display("test boot_primary done");
    lsoc_edges(5, 1'b0);
    kick(0);
    chk_wdt();
    $display("test stopped_watchdog done");
    boot(1'b1);
    $display("test boot_swap done");
    apb(1'b1, ad(OBL_IDX_MASK), 32'h0000_000F);
    m_mask = 15;
    chk_wdt();
    clr(8);
    lsoc_edges(10, 1'b1);
    chk_wdt();
    kick(PER / 2);
    chk_wdt();
    $display("test early_restart done");
    standby_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    lsoc_edges(5, 1'b1);
    standby_i <= 1'b0;
    chk_wdt();
    $display("test standby_halt done");
    lsoc_edges(PER * 3 / 4, 1'b1);
    chk_wdt();
    lsoc_edges(PER / 4, 1'b1);
    chk_wdt();
    $display("test interval_overflow done");
    lsoc_edges(40, 1'b1);
    kick(PER / 2);
    chk_wdt();
    apb(1'b1, ad(OBL_IDX_MASK), 32'h0000_0000);
    m_mask = 0;
    chk_wdt();
    clr(15);
    chk_wdt();
    $display("test late_restart_mask done");
    close_out();
  end
endmodule
`default_nettype wire
